// *** lmsp_defines.svh ***
`ifndef LMSP_DEFINES_SVH
`define LMSP_DEFINES_SVH

// Serial unit width in bits.
`define LMSP_UNIT_BITS 8
// Bit counter value on the last bit of a unit.
`define LMSP_LAST_BIT 3'h7
// Command byte field positions.
`define LMSP_CMD_DIR_BIT 7
`define LMSP_CMD_SEL_HI 6
`define LMSP_CMD_SEL_LO 4
`define LMSP_CMD_PAGE_HI 3
`define LMSP_CMD_PAGE_LO 0
// Highest page bit that the two-bit page output keeps.
`define LMSP_CMD_PAGE_USED_HI 1
// Direction flag values.
`define LMSP_DIR_WRITE 1'h0
`define LMSP_DIR_READ 1'h1
// Page selector values.
`define LMSP_PAGE_ZERO 4'h0
`define LMSP_PAGE_ONE 4'h1
`define LMSP_PAGE_TWO 4'h2
// Device select value this port answers to; the value is arbitrary.
`define LMSP_SELECT_DEFAULT 3'h3
// Highest allowed serial clock in MHz.
`define LMSP_SCK_MAX_MHZ 12

`endif

// *** lmsp_pkg.sv ***
package lmsp_pkg;

  // Transfer phase of the serial port.
  typedef enum logic [1:0] {
    LMSP_CMD,
    LMSP_ADDR,
    LMSP_DATA,
    LMSP_IGNORE
  } lmsp_phase_t;

endpackage

// *** led_matrix_spi_register_port.sv ***
// What this block does
// - Sample input on rising clock edge.
// - Every serial unit is eight bits.
// - Command: direction, device select, page fields.
// - Direction zero writes, one reads.
// - Page values zero, one, two select pages.
// - Write increments address one cycle after its strobe.
// - Further bytes go to incremented address.
// - Read drives register contents after address.
// - Read advances address on eighth edge.
// - Shutdown rising edge resets serial logic.
`timescale 1ns/1ps
`include "lmsp_defines.svh"

module led_matrix_spi_register_port #(
  parameter logic [2:0] DEV_SELECT = `LMSP_SELECT_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       shutdown_input,
  output logic            miso,
  output logic            misoOe,
  output logic            regWrite,
  output logic            regRead,
  output logic [1:0]      regPage,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata,
  input  wire logic [7:0] regRdata
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------

  logic [1:0] rstSync;     // Reset release chain.
  logic       rstN;        // Synchronised reset used everywhere.
  logic [3:0] pinMeta;     // First stage, read only by second stage.
  logic [3:0] pinSync;     // Second stage: csN, sck, mosi, shutdown.
  logic [3:0] pinPrev;     // Previous synced value for edge detection.

  // The shift and count logic only serves eight-bit units.
  if (`LMSP_UNIT_BITS != 8)
  begin : gBadWidth
    $error("Unit width must be eight bits.");
  end

  // Reset is asserted asynchronously and released through two flops.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'h1};
    end
  end
  assign rstN = rstSync[1];

  // Pins come from outside, so each passes two flops before use.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinMeta <= 4'h1;
      pinSync <= 4'h1;
      pinPrev <= 4'h1;
    end
    else
    begin
      pinMeta <= {shutdown_input, mosi, sck, csN};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Edge events derived from the second stage only.
  logic csLow;
  logic sckRise;
  logic sckFall;
  logic sdRise;
  logic csFall;
  assign csLow   = ~pinSync[0];
  assign csFall  = pinPrev[0] & ~pinSync[0];
  assign sckRise = ~pinPrev[1] & pinSync[1];
  assign sckFall = pinPrev[1] & ~pinSync[1];
  assign sdRise  = ~pinPrev[3] & pinSync[3];

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // The sampled clock is oversampled at 50 MHz; a 12 MHz serial clock
  // still gives at least two samples per phase, which is why the
  // serial clock ceiling must be respected by the controller.

  lmsp_pkg::lmsp_phase_t phase;       // Current transfer phase.
  lmsp_pkg::lmsp_phase_t next_phase;
  logic [2:0] bitCnt;                  // Bits received in this unit.
  logic [2:0] next_bitCnt;
  logic [6:0] shiftIn;                 // Bits received so far.
  logic [6:0] next_shiftIn;
  logic [7:0] shiftOut;                // Read data shifting out.
  logic [7:0] next_shiftOut;
  logic       dirRead;                 // Latched direction flag.
  logic       next_dirRead;
  logic       active;                  // Chip select seen falling.
  logic       next_active;
  logic       loadPend;                // Read data is due next cycle.
  logic       next_loadPend;
  logic       next_miso;
  logic       next_misoOe;
  logic       next_regWrite;
  logic       next_regRead;
  logic [1:0] next_regPage;
  logic [7:0] next_regAddr;
  logic [7:0] next_regWdata;
  logic [7:0] unitByte;                // Completed unit, MSB first.

  assign unitByte = {shiftIn, pinSync[2]};

  // Next-state computation for the whole transfer engine.
  always_comb
  begin
    next_phase    = phase;
    next_bitCnt   = bitCnt;
    next_shiftIn  = shiftIn;
    next_shiftOut = shiftOut;
    next_dirRead  = dirRead;
    next_active   = active;
    next_loadPend = 1'h0;
    next_miso     = miso;
    next_misoOe   = misoOe;
    next_regWrite = 1'h0;
    next_regRead  = 1'h0;
    next_regPage  = regPage;
    next_regAddr  = regAddr;
    next_regWdata = regWdata;
    if (sdRise || !csLow)
    begin
      next_phase  = lmsp_pkg::LMSP_CMD;
      next_bitCnt = 3'h0;
      next_active = 1'h0;
      next_misoOe = 1'h0;
      next_miso   = 1'h0;
    end
    else
    begin
      if (csFall)
      begin
        next_active = 1'h1;
      end
      if (loadPend)
      begin
        next_shiftOut = regRdata;
      end
      if (active && sckRise)
      begin
        next_shiftIn = unitByte[6:0];
        next_bitCnt  = bitCnt + 3'h1;
        if (phase == lmsp_pkg::LMSP_DATA && dirRead)
        begin
          next_shiftOut = {shiftOut[6:0], 1'h0};
        end
        if (bitCnt == `LMSP_LAST_BIT)
        begin
          case (phase)
            lmsp_pkg::LMSP_CMD:
            begin
              next_dirRead = unitByte[`LMSP_CMD_DIR_BIT] == `LMSP_DIR_READ;
              next_regPage = unitByte[`LMSP_CMD_PAGE_USED_HI:`LMSP_CMD_PAGE_LO];
              if (unitByte[`LMSP_CMD_SEL_HI:`LMSP_CMD_SEL_LO] == DEV_SELECT &&
                  (unitByte[`LMSP_CMD_PAGE_HI:`LMSP_CMD_PAGE_LO] == `LMSP_PAGE_ZERO ||
                   unitByte[`LMSP_CMD_PAGE_HI:`LMSP_CMD_PAGE_LO] == `LMSP_PAGE_ONE ||
                   unitByte[`LMSP_CMD_PAGE_HI:`LMSP_CMD_PAGE_LO] == `LMSP_PAGE_TWO))
              begin
                next_phase = lmsp_pkg::LMSP_ADDR;
              end
              else
              begin
                // Another device or a bad page: stay silent.
                next_phase = lmsp_pkg::LMSP_IGNORE;
              end
            end
            lmsp_pkg::LMSP_ADDR:
            begin
              next_regAddr = unitByte;
              next_phase   = lmsp_pkg::LMSP_DATA;
              if (dirRead)
              begin
                next_regRead  = 1'h1;
                next_loadPend = 1'h1;
              end
            end
            lmsp_pkg::LMSP_DATA:
            begin
              if (!dirRead)
              begin
                next_regWdata = unitByte;
                next_regWrite = 1'h1;
              end
              else
              begin
                // read advance
                // The pointer steps with the strobe so the fetch sees the next register.
                next_regAddr  = regAddr + 8'h1;
                next_regRead  = 1'h1;
                next_loadPend = 1'h1;
              end
            end
            default:
            begin
              next_phase = lmsp_pkg::LMSP_IGNORE;
            end
          endcase
        end
      end
      // Address advances one cycle after the write strobe uses it.
      if (regWrite)
      begin
        next_regAddr = regAddr + 8'h1;
      end
      if (active && sckFall && phase == lmsp_pkg::LMSP_DATA && dirRead)
      begin
        next_misoOe = 1'h1;
        next_miso   = shiftOut[`LMSP_UNIT_BITS - 1];
      end
    end
  end

  // Registers of the transfer engine.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      phase    <= lmsp_pkg::LMSP_CMD;
      bitCnt   <= 3'h0;
      shiftIn  <= 7'h00;
      shiftOut <= 8'h00;
      dirRead  <= 1'h0;
      active   <= 1'h0;
      loadPend <= 1'h0;
      miso     <= 1'h0;
      misoOe   <= 1'h0;
      regWrite <= 1'h0;
      regRead  <= 1'h0;
      regPage  <= 2'h0;
      regAddr  <= 8'h00;
      regWdata <= 8'h00;
    end
    else
    begin
      phase    <= next_phase;
      bitCnt   <= next_bitCnt;
      shiftIn  <= next_shiftIn;
      shiftOut <= next_shiftOut;
      dirRead  <= next_dirRead;
      active   <= next_active;
      loadPend <= next_loadPend;
      miso     <= next_miso;
      misoOe   <= next_misoOe;
      regWrite <= next_regWrite;
      regRead  <= next_regRead;
      regPage  <= next_regPage;
      regAddr  <= next_regAddr;
      regWdata <= next_regWdata;
    end
  end

endmodule

// *** lmsp_checker_asserts.sv ***
`timescale 1ns/1ps
// ----
// Port checker
// ----
module lmsp_checker_asserts (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       csN,
  input wire logic       shutdown_input,
  input wire logic       misoOe,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [1:0] regPage,
  input wire logic [7:0] regAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Chip select idle long enough to pass the pin synchroniser.
  sequence csIdle;
    csN [*8];
  endsequence
  // A strobe, then the pointer step that follows it.
  sequence wrStep;
    regWrite ##1 !regWrite;
  endsequence
  // A data-phase read strobe: the output is already driven then.
  sequence rdStep;
    regRead && misoOe;
  endsequence
  a_write_pulse_once: assert property (regWrite |=> !regWrite)
    else $error("long write");
  a_read_pulse_once: assert property (regRead |=> !regRead)
    else $error("long read");
  a_addr_step_write: assert property (wrStep |-> regAddr == $past(regAddr) + 8'h01)
    else $error("no address step");
  a_addr_step_read: assert property (rdStep |-> regAddr == $past(regAddr) + 8'h01)
    else $error("no read address step");
  a_dir_exclusive: assert property (!(regWrite && regRead))
    else $error("write and read");
  a_page_legal: assert property ((regWrite || regRead) |-> regPage != 2'h3)
    else $error("bad page");
  a_needs_select: assert property ((regWrite || regRead) |-> !$past(csN, 4))
    else $error("access without select");
  a_oe_release: assert property ($rose(csN) |-> ##[1:8] !misoOe)
    else $error("oe held");
  a_idle_quiet: assert property (csIdle |-> !misoOe && !regWrite && !regRead)
    else $error("idle activity");
  a_shutdown_clear: assert property ($rose(shutdown_input) |-> ##[1:8] !misoOe)
    else $error("oe after shutdown");
endmodule

bind led_matrix_spi_register_port lmsp_checker_asserts lmsp_checker_asserts_inst (
  .clk(clk), .nrst(nrst), .csN(csN), .shutdown_input(shutdown_input), .misoOe(misoOe),
  .regWrite(regWrite), .regRead(regRead), .regPage(regPage), .regAddr(regAddr));

// *** lmsp_host_model.sv ***
`timescale 1ns/1ps
// ----
// Serial controller model
// ----
module lmsp_host_model (
  input  wire logic clk,
  output logic      csN,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic misoOe
);
  // Five cycles a phase keeps the clock at 5 MHz, well inside the limit.
  // clock rate limit
  localparam int HALF = 5;
  logic lastBit = 1'b0;
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic open_xfer();
    wait_clk(HALF);
    csN = 1'b0;
    wait_clk(HALF);
  endtask
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      mosi = tx[i];
      wait_clk(HALF);
      sck = 1'b1;
      // A released line shows the opposite of its last level.
      rx[i] = misoOe ? miso : ~lastBit;
      lastBit = rx[i];
      wait_clk(HALF);
      sck = 1'b0;
    end
  endtask
  task automatic close_xfer();
    wait_clk(HALF);
    csN = 1'b1;
    mosi = ~mosi;
    wait_clk(4 * HALF);
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        shutdown_input = 1'b0;
  logic        csN, sck, mosi, miso, misoOe, regWrite, regRead;
  logic [1:0]  regPage;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [7:0]  rx [2];
  logic [17:0] wq [$];
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          rdCount = 0;
  always #10 clk = ~clk;
  // Register file stand-in: contents follow the address.
  assign regRdata = regAddr ^ 8'h5a;
  led_matrix_spi_register_port led_matrix_spi_register_port_inst (.clk(clk), .nrst(nrst),
    .csN(csN), .sck(sck), .mosi(mosi), .shutdown_input(shutdown_input), .miso(miso),
    .misoOe(misoOe), .regWrite(regWrite), .regRead(regRead), .regPage(regPage),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  lmsp_host_model host (.clk(clk), .csN(csN), .sck(sck), .mosi(mosi), .miso(miso),
    .misoOe(misoOe));
  // Log every write strobe and cut a hang short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (regWrite === 1'b1) wq.push_back({regPage, regAddr, regWdata});
    if (regRead === 1'b1) rdCount <= rdCount + 1;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] cmd, addr, d, input int n);
    wq.delete();
    host.open_xfer();
    host.shift(cmd, 8, rx[0]);
    host.shift(addr, 8, rx[0]);
    for (int i = 0; i < n; i++) host.shift(i == 0 ? d : 8'h3c, 8, rx[i]);
    host.close_xfer();
  endtask
  task automatic test_write();
    for (int p = 0; p < 3; p++)
    begin
      xfer({1'b0, 3'h3, 4'(p)}, 8'h10, 8'ha0 + 8'(p), 2);
      check("write count", 18'h2, 18'(wq.size()));
      check("first write", {2'(p), 8'h10, 8'ha0 + 8'(p)}, wq[0]);
      check("second write", {2'(p), 8'h11, 8'h3c}, wq[1]);
    end
    $display("test_write done");
  endtask
  task automatic test_read();
    int r0;
    r0 = rdCount;
    xfer(8'hb2, 8'h20, 8'h00, 2);
    check("read strobes", 18'h3, 18'(rdCount - r0));
    check("read page", 18'h2, 18'(regPage));
    check("first read", 18'(8'h20 ^ 8'h5a), 18'(rx[0]));
    check("second read", 18'(8'h21 ^ 8'h5a), 18'(rx[1]));
    check("read writes", 18'h0, 18'(wq.size()));
    $display("test_read done");
  endtask
  task automatic test_refused();
    xfer(8'h52, 8'h10, 8'h11, 1);
    check("wrong select", 18'h0, 18'(wq.size()));
    xfer(8'h33, 8'h10, 8'h11, 1);
    check("wrong page", 18'h0, 18'(wq.size()));
    $display("test_refused done");
  endtask
  task automatic test_abort();
    host.open_xfer();
    host.shift(8'hb2, 8, rx[0]);
    host.shift(8'h20, 8, rx[0]);
    host.shift(8'h00, 3, rx[0]);
    shutdown_input = 1'b1;
    host.wait_clk(10);
    check("oe after shutdown", 18'h0, 18'(misoOe));
    shutdown_input = 1'b0;
    host.close_xfer();
    host.open_xfer();
    host.shift(8'h03, 4, rx[0]);
    host.close_xfer();
    xfer(8'h30, 8'h40, 8'h77, 1);
    check("write after abort", {2'h0, 8'h40, 8'h77}, wq[0]);
    check("abort count", 18'h1, 18'(wq.size()));
    $display("test_abort done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clk);
    test_write();
    test_read();
    test_refused();
    test_abort();
    end_sim();
  end
endmodule
